// [rtl/sps_buf2.v]
`timescale 1ns/1ps
module sps_buf2 (
  input  wire       clock,
  input  wire       rst,
  input  wire       clr,
  input  wire       in_valid,
  output wire       in_ready,
  input  wire [7:0] in_data,
  output wire       out_valid,
  input  wire       out_ready,
  output wire [7:0] out_data
);
  localparam WIDTH = 8;
  localparam DEPTH = 2;

  reg  [1:0]       cnt_ff;
  reg              wr_ptr_ff;
  reg              rd_ptr_ff;
  wire [WIDTH-1:0] ent [0:DEPTH-1];
  wire             push;
  wire             pop;

  assign in_ready  = (cnt_ff != 2'h2);
  assign out_valid = (cnt_ff != 2'h0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = ent[rd_ptr_ff];

  // ----------------------------------------
  // Entry storage
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < DEPTH; i = i + 1) begin : g_ent
      reg [WIDTH-1:0] data_ff;
      always @(posedge clock) begin
        if (rst) begin
          data_ff <= 8'h00;
        end else if (push && (wr_ptr_ff == i)) begin
          data_ff <= in_data;
        end
      end
      assign ent[i] = data_ff;
    end
  endgenerate

  // ----------------------------------------
  // Pointers
  // ----------------------------------------
  always @(posedge clock) begin
    if (rst || clr) begin
      cnt_ff    <= 2'h0;
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_ff <= ~wr_ptr_ff;
      end
      if (pop) begin
        rd_ptr_ff <= ~rd_ptr_ff;
      end
      if (push && !pop) begin
        cnt_ff <= cnt_ff + 2'h1;
      end else if (pop && !push) begin
        cnt_ff <= cnt_ff - 2'h1;
      end
    end
  end
endmodule // sps_buf2

// [rtl/sps_port.v]
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "sps_regs.vh"
module sps_port (
  input  wire       clock,
  input  wire       rst,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output wire [7:0] reg_rdata,
  input  wire       sclk_in,
  output wire       sclk_out,
  output wire       sclk_oe,
  input  wire       sdi,
  output wire       sdo,
  output wire       sdo_oe,
  input  wire       ste_n_in,
  output wire       ste_n_out,
  output wire       ste_n_oe
);
  localparam integer HALF_CYC  = `SPS_HALF_CYC;
  localparam [2:0]   HALF_LAST = HALF_CYC[2:0] - 3'h1;

  reg  [7:0] ctrl_ff;
  reg  [7:0] rdata_ff;
  reg  [7:0] rx_hold_ff;
  reg        rx_full_ff;
  reg        abort_ff;
  reg        overrun_ff;
  reg  [2:0] sync1_ff;
  reg  [2:0] sync2_ff;
  reg  [2:0] sync3_ff;
  reg  [2:0] filt_ff;
  reg        prev_sclk_ff;
  reg        armed_ff;
  reg  [7:0] tx_shift_ff;
  reg  [7:0] rx_shift_ff;
  reg  [2:0] tx_cnt_ff;
  reg  [2:0] rx_cnt_ff;
  reg        loaded_ff;
  reg        m_busy_ff;
  reg  [2:0] m_half_ff;
  reg  [3:0] m_edge_ff;
  reg        m_sclk_ff;
  reg        m_samp_ff;

  wire srst    = ctrl_ff[`SPS_CTRL_SRST];
  wire cpha    = ctrl_ff[`SPS_CTRL_CPHA];
  wire cpol    = ctrl_ff[`SPS_CTRL_CPOL];
  wire master  = ctrl_ff[`SPS_CTRL_MASTER];
  wire fourpin = ctrl_ff[`SPS_CTRL_FOURPIN];
  wire stem    = ctrl_ff[`SPS_CTRL_STEM];
  wire sclk_f  = filt_ff[0];
  wire sdi_f   = filt_ff[1];
  wire ste_n_f = filt_ff[2];

  wire       buf_in_ready;
  wire       buf_out_valid;
  wire [7:0] buf_out_data;
  wire       buf_pop;

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  wire wr_ctrl = reg_wr && (reg_addr == `SPS_OFS_CTRL);
  wire wr_tx   = reg_wr && (reg_addr == `SPS_OFS_TXBUF) && !srst;
  wire wr_stat = reg_wr && (reg_addr == `SPS_OFS_STAT);
  wire rd_rx   = reg_rd && (reg_addr == `SPS_OFS_RXBUF);

  always @(posedge clock) begin
    if (rst) begin
      ctrl_ff <= `SPS_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_ff <= {2'h0, reg_wdata[5:0]};
    end
  end

  // ----------------------------------------
  // Pin synchronisers, three stages
  // ----------------------------------------
  always @(posedge clock) begin
    if (rst) begin
      sync1_ff <= 3'h7;
      sync2_ff <= 3'h7;
      sync3_ff <= 3'h7;
      filt_ff  <= 3'h7;
    end else begin
      sync1_ff <= {ste_n_in, sdi, sclk_in};
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      filt_ff  <= (sync2_ff & ~(sync2_ff ^ sync3_ff)) | (filt_ff & (sync2_ff ^ sync3_ff));
    end
  end

  // ----------------------------------------
  // Slave clock edges
  // ----------------------------------------
  // Edges count only once the clock was seen idle after reset release
  wire s_sel   = !fourpin || !ste_n_f;
  wire s_run   = !master && !srst && armed_ff && s_sel;
  wire s_lead  = s_run && (prev_sclk_ff == cpol) && (sclk_f != cpol);
  wire s_trail = s_run && (prev_sclk_ff != cpol) && (sclk_f == cpol);

  always @(posedge clock) begin
    if (rst) begin
      prev_sclk_ff <= 1'b1;
      armed_ff     <= 1'b0;
    end else begin
      prev_sclk_ff <= sclk_f;
      if (srst || master) begin
        armed_ff <= 1'b0;
      end else if (sclk_f == cpol) begin
        armed_ff <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Master clock generator
  // ----------------------------------------
  wire m_allow = !fourpin || stem || !ste_n_f;
  wire m_start = master && !srst && !m_busy_ff && !m_samp_ff && m_allow && buf_out_valid;
  wire m_abort = m_busy_ff && (!m_allow || srst);
  wire m_tick  = m_busy_ff && m_allow && (m_half_ff == HALF_LAST);
  wire m_lead  = m_tick && !m_edge_ff[0];
  wire m_trail = m_tick && m_edge_ff[0];

  always @(posedge clock) begin
    if (rst) begin
      m_busy_ff <= 1'b0;
      m_half_ff <= 3'h0;
      m_edge_ff <= 4'h0;
      m_sclk_ff <= 1'b0;
    end else if (m_abort) begin
      m_busy_ff <= 1'b0;
      m_sclk_ff <= cpol;
    end else if (m_start) begin
      m_busy_ff <= 1'b1;
      m_half_ff <= 3'h0;
      m_edge_ff <= 4'h0;
      m_sclk_ff <= cpol;
    end else if (m_busy_ff) begin
      if (m_tick) begin
        m_half_ff <= 3'h0;
        m_edge_ff <= m_edge_ff + 4'h1;
        m_sclk_ff <= ~m_sclk_ff;
        if (m_edge_ff == 4'hf) begin
          m_busy_ff <= 1'b0;
        end
      end else begin
        m_half_ff <= m_half_ff + 3'h1;
      end
    end else begin
      m_sclk_ff <= cpol;
    end
  end

  // Phase 1 master samples one clock after its trailing edge, past the pin delay
  always @(posedge clock) begin
    if (rst) begin
      m_samp_ff <= 1'b0;
    end else begin
      m_samp_ff <= m_trail && !m_abort;
    end
  end

  // ----------------------------------------
  // Shift core, shared by both modes
  // ----------------------------------------
  wire ev_lead   = master ? m_lead : s_lead;
  wire ev_trail  = master ? m_trail : s_trail;
  wire sample_ev = master ? (cpha ? m_samp_ff : m_lead) : (cpha ? s_trail : s_lead);
  wire shift_ev  = cpha ? ev_lead : ev_trail;
  wire s_load    = !master && !srst && s_sel && !loaded_ff && buf_out_valid;
  wire byte_done = sample_ev && (rx_cnt_ff == 3'h7);
  wire idle_core = srst || (!master && !s_sel) || m_abort;

  assign buf_pop = m_start || s_load;

  always @(posedge clock) begin
    if (rst) begin
      tx_shift_ff <= 8'h00;
      rx_shift_ff <= 8'h00;
      tx_cnt_ff   <= 3'h0;
      rx_cnt_ff   <= 3'h0;
      loaded_ff   <= 1'b0;
    end else if (idle_core) begin
      tx_cnt_ff <= 3'h0;
      rx_cnt_ff <= 3'h0;
      if (srst || m_abort) begin
        tx_shift_ff <= 8'h00;
        loaded_ff   <= 1'b0;
      end
    end else if (buf_pop) begin
      tx_shift_ff <= buf_out_data;
      loaded_ff   <= 1'b1;
    end else begin
      if (sample_ev) begin
        rx_shift_ff <= {rx_shift_ff[6:0], sdi_f};
        rx_cnt_ff   <= rx_cnt_ff + 3'h1;
        if (!loaded_ff) begin
          loaded_ff <= 1'b1;
        end
      end
      if (shift_ev) begin
        tx_cnt_ff <= tx_cnt_ff + 3'h1;
        // First leading edge with phase 1 keeps the top bit on the line
        if (!cpha || (tx_cnt_ff != 3'h0)) begin
          tx_shift_ff <= {tx_shift_ff[6:0], 1'b0};
        end
      end
      if ((!cpha && shift_ev && (tx_cnt_ff == 3'h7)) || (cpha && byte_done)) begin
        loaded_ff   <= 1'b0;
        tx_shift_ff <= 8'h00;
      end
    end
  end

  // ----------------------------------------
  // Receive holding buffer and flags
  // ----------------------------------------
  always @(posedge clock) begin
    if (rst) begin
      rx_hold_ff <= 8'h00;
      rx_full_ff <= 1'b0;
      overrun_ff <= 1'b0;
      abort_ff   <= 1'b0;
    end else begin
      if (srst) begin
        rx_full_ff <= 1'b0;
      end else if (byte_done && !idle_core) begin
        rx_hold_ff <= {rx_shift_ff[6:0], sdi_f};
        rx_full_ff <= 1'b1;
      end else if (rd_rx) begin
        rx_full_ff <= 1'b0;
      end
      if (byte_done && !idle_core && rx_full_ff && !rd_rx) begin
        overrun_ff <= 1'b1;
      end else if (wr_stat && reg_wdata[`SPS_STAT_OVERRUN]) begin
        overrun_ff <= 1'b0;
      end
      if (m_abort && !srst) begin
        abort_ff <= 1'b1;
      end else if (wr_stat && reg_wdata[`SPS_STAT_ABORT]) begin
        abort_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Transmit holding buffer
  // ----------------------------------------
  sps_buf2 u_txbuf (
    .clock     (clock),
    .rst       (rst),
    .clr       (srst),
    .in_valid  (wr_tx),
    .in_ready  (buf_in_ready),
    .in_data   (reg_wdata),
    .out_valid (buf_out_valid),
    .out_ready (buf_pop),
    .out_data  (buf_out_data)
  );

  // ----------------------------------------
  // Read data, one cycle after the strobe
  // ----------------------------------------
  wire [7:0] stat_word = {3'h0, overrun_ff, abort_ff, m_busy_ff, buf_in_ready, rx_full_ff};

  always @(posedge clock) begin
    if (rst) begin
      rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `SPS_OFS_CTRL:  rdata_ff <= ctrl_ff;
        `SPS_OFS_RXBUF: rdata_ff <= rx_hold_ff;
        `SPS_OFS_STAT:  rdata_ff <= stat_word;
        default:        rdata_ff <= 8'h00;
      endcase
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  // ----------------------------------------
  // Pins
  // ----------------------------------------
  assign reg_rdata = rdata_ff;
  assign sclk_out  = (m_busy_ff && !srst) ? m_sclk_ff : cpol;
  assign sclk_oe   = master && !srst && m_allow;
  assign sdo       = tx_shift_ff[7];
  assign sdo_oe    = !srst && (master ? m_allow : s_sel);
  assign ste_n_out = !m_busy_ff;
  assign ste_n_oe  = master && fourpin && stem && !srst;
endmodule // sps_port

// [shared/sps_regs.vh]
`ifndef SPS_REGS_VH
`define SPS_REGS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SPS_OFS_CTRL      8'h00
`define SPS_OFS_TXBUF     8'h04
`define SPS_OFS_RXBUF     8'h08
`define SPS_OFS_STAT      8'h0c

// ----------------------------------------
// Control word zero fields
// ----------------------------------------
`define SPS_CTRL_SRST     0
`define SPS_CTRL_CPHA     1
`define SPS_CTRL_CPOL     2
`define SPS_CTRL_MASTER   3
`define SPS_CTRL_FOURPIN  4
`define SPS_CTRL_STEM     5
`define SPS_CTRL_RST      8'h01

// ----------------------------------------
// Status fields
// ----------------------------------------
`define SPS_STAT_RXFULL   0
`define SPS_STAT_TXEMPTY  1
`define SPS_STAT_BUSY     2
`define SPS_STAT_ABORT    3
`define SPS_STAT_OVERRUN  4

// ----------------------------------------
// Timing
// ----------------------------------------
`define SPS_CLK_NS        25
`define SPS_HALF_NS       100
`define SPS_HALF_CYC      (`SPS_HALF_NS / `SPS_CLK_NS)

`endif

// [testbench/sps_port_properties.sv]
`timescale 1ns/1ps
module sps_port_properties (
  input logic       clock,
  input logic       rst,
  input logic [7:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic       reg_wr,
  input logic       reg_rd,
  input logic [7:0] reg_rdata,
  input logic       sclk_out,
  input logic       sclk_oe,
  input logic       sdo_oe,
  input logic       ste_n_in,
  input logic       ste_n_out,
  input logic       ste_n_oe
);
  // Shadow of the control word, kept from the bus
  logic [5:0] ctl_ff;
  logic       mode0;
  always_ff @(posedge clock) begin
    if (rst)
      ctl_ff <= 6'h01;
    else if (reg_wr && reg_addr == 8'h00)
      ctl_ff <= reg_wdata[5:0];
  end
  assign mode0 = ctl_ff[4:3] == 2'h3 && !ctl_ff[5] && !ctl_ff[0];
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  chk_idle_level: assert property (ctl_ff[0] |-> sclk_out == ctl_ff[2])
    else $error("serial clock not at idle level");
  chk_srst_quiet: assert property (ctl_ff[0] |-> !sclk_oe && !sdo_oe && !ste_n_oe)
    else $error("pins driven in soft reset");
  chk_ste_drive: assert property (1'b1 |-> ste_n_oe == (ctl_ff[5:3] == 3'h7 && !ctl_ff[0]))
    else $error("select output enable wrong");
  chk_ste_frame: assert property (ctl_ff[5:3] == 3'h7 && $fell(ste_n_out) |-> ##[1:8] sclk_out != ctl_ff[2])
    else $error("no clock after select");
  chk_select_block: assert property ((mode0 && ste_n_in) [*6] |-> !sclk_oe && !sdo_oe)
    else $error("bus driven with select inactive");
  chk_abort_release: assert property (mode0 && $rose(ste_n_in) |-> ##[2:6] !sclk_oe)
    else $error("bus kept after select loss");
  chk_rx_quiet: assert property ($past(reg_rd && reg_addr == 8'h0c && ctl_ff[0]) && $past(ctl_ff[0], 2)
    |-> !reg_rdata[0])
    else $error("receive flag set in soft reset");
  chk_ctrl_read: assert property ($past(reg_rd && reg_addr == 8'h00) |-> reg_rdata == {2'h0, $past(ctl_ff)})
    else $error("control word readback wrong");
endmodule // sps_port_properties

// [testbench/sps_spi_master.sv]
`timescale 1ns/1ps
module sps_spi_master (
  output reg  sclk,
  output reg  mosi,
  output reg  ste_n,
  input  wire miso
);
  reg cpol = 1'b0;
  reg cpha = 1'b0;
  initial begin
    sclk = 1'b0;
    mosi = 1'b0;
    ste_n = 1'b1;
  end
  task setup(input p, input h);
    begin
      cpol <= p;
      cpha <= h;
      sclk <= p;
    end
  endtask
  // Sample just before the slave's next shift edge
  task xfer(input [7:0] d, output [7:0] q);
    integer i;
    begin
      #37 ste_n = 1'b0;
      for (i = 7; i >= 0; i = i - 1) begin
        if (!cpha) mosi = d[i];
        #99 if (cpha && i < 7) q[i + 1] = miso;
        #1 sclk = ~cpol;
        if (cpha) mosi = d[i];
        #99 if (!cpha) q[i] = miso;
        #1 sclk = cpol;
      end
      #99 if (cpha) q[0] = miso;
      #1 ste_n = 1'b1;
      mosi = ~mosi;
    end
  endtask
endmodule // sps_spi_master

// [testbench/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        rd_d = 1'b0;
  logic        mst = 1'b0;
  logic        ste_tb = 1'b1;
  wire  [7:0]  reg_rdata;
  wire         m_sclk, m_mosi, m_ste, sclk_out, sclk_oe, sdo, sdo_oe, ste_n_out, ste_n_oe;
  wire         sdo_line = sdo_oe ? sdo : ~sdo;
  wire         sdi = mst ? sdo_line : m_mosi;
  wire         ste_n_in = mst ? ste_tb : m_ste;
  integer      errors = 0;
  integer      num_checks = 0;
  integer      seed = 69;
  integer      i;
  logic [15:0] expq[$];
  logic [15:0] e;
  logic [7:0]  t, r, q;
  always #12.5 clock = ~clock;
  sps_port dut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sclk_in(m_sclk), .sclk_out(sclk_out), .sclk_oe(sclk_oe),
    .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .ste_n_in(ste_n_in), .ste_n_out(ste_n_out), .ste_n_oe(ste_n_oe));
  sps_spi_master m (.sclk(m_sclk), .mosi(m_mosi), .ste_n(m_ste), .miso(sdo_line));
  task check(input string nm, input [7:0] ex, input [7:0] got, input [7:0] msk);
    begin
      num_checks = num_checks + 1;
      if ((got & msk) !== (ex & msk)) begin
        errors = errors + 1;
        $display("mismatch %s expected %h seen %h", nm, ex & msk, got & msk);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
      @(posedge clock);
    end
  endtask
  task rd(input [7:0] a, input [7:0] ex, input [7:0] msk);
    begin
      expq.push_back({msk, ex});
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      @(posedge clock);
    end
  endtask
  always @(posedge clock) begin
    if (rd_d) begin
      e = expq.pop_front();
      check("reg_rdata", e[7:0], reg_rdata, e[15:8]);
    end
    rd_d <= reg_rd;
  end
  task wait_done;
    integer n;
    begin
      n = 0;
      while (ste_n_out !== 1'b0 && n < 40) begin
        @(posedge clock);
        n = n + 1;
      end
      check("frame_start", 8'h01, {7'h0, n < 40}, 8'h01);
      while (ste_n_out !== 1'b1 && n < 300) begin
        @(posedge clock);
        n = n + 1;
      end
      check("frame_end", 8'h01, {7'h0, n < 300}, 8'h01);
      repeat (4) @(posedge clock);
    end
  endtask
  task close_out;
    begin
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rd(8'h00, 8'h01, 8'hff);
    rd(8'h10, 8'h00, 8'hff);
    rd(8'h0c, 8'h02, 8'h1f);
    m.xfer(8'h5a, q);
    repeat (8) @(posedge clock);
    rd(8'h0c, 8'h00, 8'h01);
    rd(8'h0c, 8'h02, 8'h03);
    wr(8'h00, 8'h00);
    m.xfer(8'h5a, q);
    check("zero_fill", 8'h00, q, 8'hff);
    repeat (8) @(posedge clock);
    rd(8'h0c, 8'h01, 8'h01);
    rd(8'h08, 8'h5a, 8'hff);
    for (i = 0; i < 4; i = i + 1) begin
      t = 8'($random(seed));
      r = 8'($random(seed));
      wr(8'h00, {5'h0, i[1:0], 1'b1});
      m.setup(i[1], i[0]);
      wr(8'h00, {5'h0, i[1:0], 1'b0});
      wr(8'h04, t);
      m.xfer(r, q);
      @(posedge clock);
      check("slave_sdo", t, q, 8'hff);
      repeat (8) @(posedge clock);
      rd(8'h0c, 8'h01, 8'h01);
      rd(8'h08, r, 8'hff);
      rd(8'h0c, 8'h00, 8'h01);
    end
    mst <= 1'b1;
    wr(8'h00, 8'h3f);
    wr(8'h00, 8'h3e);
    wr(8'h04, t);
    wr(8'h04, r);
    wait_done;
    wait_done;
    rd(8'h0c, 8'h11, 8'h11);
    rd(8'h08, r, 8'hff);
    ste_tb <= 1'b0;
    wr(8'h00, 8'h19);
    wr(8'h00, 8'h18);
    wr(8'h04, t);
    repeat (20) @(posedge clock);
    ste_tb <= 1'b1;
    repeat (10) @(posedge clock);
    rd(8'h0c, 8'h08, 8'h0c);
    ste_tb <= 1'b0;
    repeat (100) @(posedge clock);
    rd(8'h0c, 8'h08, 8'h0d);
    wr(8'h04, r);
    wait_done;
    rd(8'h08, r, 8'hff);
    close_out;
  end
  initial begin
    #1000000;
    errors = errors + 1;
    close_out;
  end
endmodule // tb_top
bind sps_port sps_port_properties chk (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sclk_out(sclk_out), .sclk_oe(sclk_oe),
  .sdo_oe(sdo_oe), .ste_n_in(ste_n_in), .ste_n_out(ste_n_out), .ste_n_oe(ste_n_oe));
